// >>> src/lcs_defines.vh
// constants for the antenna supply control and status register bank
//------------------------------------------------------------
// Functional notes
// - current monitor enable at 1 enables current diagnostic and forces 21 V level.
// - overload recovery latch at 1: overload clears voltage select, output off.
// - overload recovery latch at 0: output returns when overload clears, select kept.
// - thermal recovery latch at 1: overtemperature clears voltage select, output off.
// - thermal recovery latch at 0: output returns when overtemperature clears, select kept.
// - compensation bit 1 selects high-ESR, 0 selects low-ESR compensation.
// - protection control and both status registers reset to zero.
// - status registers are read only; writes to them are ignored.
// - status one bit 0 shows output overload.
// - status one bit 2 shows output voltage below monitor thresholds.
// - status one bit 4 shows pull-down overcurrent persisting past deglitch time.
// - status one bit 6 sets above 150 C, clears below 135 C.
// - status one bit 7 shows supply input undervoltage.
// - status two bit 0 shows 22 kHz tone detected on tone input.
// - status two bit 2 shows tone frequency or amplitude out of limits.
// - status two bit 4 shows output current below monitor threshold.
// - reading voltage select returns written bits 0 to 3; policy returns written bits 0, 3, 6, 7.
// - voltage select is bits 0 to 3 of control register at address 0x2.
//------------------------------------------------------------
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH
`define LCS_ADDR_DIAG_STATUS 3'h0
`define LCS_ADDR_TONE_STATUS 3'h1
`define LCS_ADDR_VSEL_CTRL 3'h2
`define LCS_ADDR_POLICY_CTRL 3'h5
`define LCS_RESET_BYTE 8'h00
`define LCS_POL_OUTPUT_CURRENT_LOW_FLAG_EN 0
`define LCS_POL_OLR 3
`define LCS_POL_THERMAL_RECOVERY_LATCH 6
`define LCS_POL_COMP 7
`define LCS_POL_MASK 8'hC9
`define LCS_VSEL_MASK 8'h0F
`define LCS_ST1_OLF 0
`define LCS_ST1_OUTPUT_VOLTAGE_LOW_FLAG 2
`define LCS_ST1_PDO 4
`define LCS_ST1_OTF 6
`define LCS_ST1_UV 7
`define LCS_ST2_TONE 0
`define LCS_ST2_TONE_OUT_OF_SPEC_FLAG 2
`define LCS_ST2_ILOW 4
`define LCS_DEGLITCH_NS 10000
`define LCS_CLK_NS 10
`define LCS_DEGLITCH_CYC ((`LCS_DEGLITCH_NS + `LCS_CLK_NS - 1) / `LCS_CLK_NS)
`endif

// >>> src/lcs_sync.v
// two flip-flop level synchroniser, parameterised width
`timescale 1ns/1ns
`default_nettype none
module lcs_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire sys_rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta;
    // first stage feeds only the second
    always @(posedge mclk) begin
        if (sys_rst) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> src/lcs_deglitch.v
// persistence filter: output high after input held high for CYC cycles
`timescale 1ns/1ns
`default_nettype none
module lcs_deglitch #(
    parameter CYC = 1000,
    parameter CW = 16
) (
    input wire mclk,
    input wire sys_rst,
    input wire din,
    output reg dout
);
    reg [CW-1:0] cnt;
    // count while condition holds, drop at once when it goes
    always @(posedge mclk) begin
        if (sys_rst || !din) begin
            cnt <= {CW{1'b0}};
            dout <= 1'b0;
        end else if (cnt >= CYC[CW-1:0] - 1'b1) begin
            dout <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> src/lcs_regs.v
// control and diagnostic status register bank of the antenna supply
`include "lcs_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module lcs_regs #(
    parameter DEGLITCH_CYC = `LCS_DEGLITCH_CYC
) (
    input wire mclk,
    input wire sys_rst,
    // register access from the serial protocol engine, same clock
    input wire wr_stb,
    input wire rd_stb,
    input wire [2:0] reg_addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg rd_valid,
    // analog condition comparators, asynchronous
    input wire overload_det,
    input wire vout_low_det,
    input wire pulldown_oc_det,
    input wire temp_above_hi,
    input wire temp_below_lo,
    input wire supply_undervoltage_threshold,
    input wire tone_detection_input,
    input wire tone_out_of_limits,
    input wire iout_below_thr,
    // controls to the analog side
    output reg [3:0] output_voltage_select,
    output reg output_enable,
    output reg diag_level_21v,
    output reg current_monitor_enable,
    output reg high_esr_comp
);
    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    wire [8:0] raw_in;
    wire [8:0] syn;
    assign raw_in = {iout_below_thr, tone_out_of_limits, tone_detection_input,
                     supply_undervoltage_threshold, temp_below_lo, temp_above_hi,
                     pulldown_oc_det, vout_low_det, overload_det};
    lcs_sync #(.W(9)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(raw_in),
        .dout(syn)
    );

    //------------------------------------------------------------
    // condition flags
    //------------------------------------------------------------
    wire overload_flag;
    wire output_voltage_low_flag;
    wire pulldown_overcurrent_flag;
    reg overtemperature_flag;
    wire input_undervoltage_flag;
    wire tone_present_flag;
    wire tone_out_of_spec_flag;
    wire output_current_low_flag;

    assign overload_flag = syn[0];
    assign output_voltage_low_flag = syn[1];
    assign input_undervoltage_flag = syn[5];
    assign tone_present_flag = syn[6];
    assign tone_out_of_spec_flag = syn[7];
    assign output_current_low_flag = syn[8];

    // pull-down overcurrent must persist past the deglitch interval
    lcs_deglitch #(.CYC(DEGLITCH_CYC), .CW(32)) u_pdo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(syn[2]),
        .dout(pulldown_overcurrent_flag)
    );

    // thermal hysteresis: set above high trip, clear below low trip
    always @(posedge mclk) begin
        if (sys_rst) begin
            overtemperature_flag <= 1'b0;
        end else if (syn[3]) begin
            overtemperature_flag <= 1'b1;
        end else if (syn[4]) begin
            overtemperature_flag <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    reg [7:0] vsel_ctrl;
    reg [7:0] policy_ctrl;
    reg ovl_latched;
    reg ot_latched;
    reg ovl_q;
    reg ot_q;
    wire ovl_rise;
    wire ot_rise;
    wire overload_recovery_latch;
    wire thermal_recovery_latch;

    assign overload_recovery_latch = policy_ctrl[`LCS_POL_OLR];
    assign thermal_recovery_latch = policy_ctrl[`LCS_POL_THERMAL_RECOVERY_LATCH];
    assign ovl_rise = overload_flag & ~ovl_q;
    assign ot_rise = overtemperature_flag & ~ot_q;

    // writes, and protection clearing of voltage select (protection wins)
    always @(posedge mclk) begin
        if (sys_rst) begin
            vsel_ctrl <= `LCS_RESET_BYTE;
            policy_ctrl <= `LCS_RESET_BYTE;
            ovl_q <= 1'b0;
            ot_q <= 1'b0;
            ovl_latched <= 1'b0;
            ot_latched <= 1'b0;
        end else begin
            ovl_q <= overload_flag;
            ot_q <= overtemperature_flag;
            if (wr_stb && reg_addr == `LCS_ADDR_POLICY_CTRL) begin
                policy_ctrl <= wr_data;
            end
            if (wr_stb && reg_addr == `LCS_ADDR_VSEL_CTRL) begin
                vsel_ctrl <= wr_data & `LCS_VSEL_MASK;
                ovl_latched <= 1'b0;
                ot_latched <= 1'b0;
            end
            // latched policies clear the select on the protection event
            if (ovl_rise && overload_recovery_latch) begin
                vsel_ctrl[3:0] <= 4'h0;
                ovl_latched <= 1'b1;
            end
            if (ot_rise && thermal_recovery_latch) begin
                vsel_ctrl[3:0] <= 4'h0;
                ot_latched <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // outputs to the regulator
    //------------------------------------------------------------
    // automatic policy: output held off only while the flag stands
    always @(posedge mclk) begin
        if (sys_rst) begin
            output_voltage_select <= 4'h0;
            output_enable <= 1'b0;
            diag_level_21v <= 1'b0;
            current_monitor_enable <= 1'b0;
            high_esr_comp <= 1'b0;
        end else begin
            output_voltage_select <= vsel_ctrl[3:0];
            // select kept, output returns when flag clears
            output_enable <= (vsel_ctrl[3:0] != 4'h0) && !overload_flag
                             && !overtemperature_flag && !ovl_latched && !ot_latched;
            current_monitor_enable <= policy_ctrl[`LCS_POL_OUTPUT_CURRENT_LOW_FLAG_EN];
            diag_level_21v <= policy_ctrl[`LCS_POL_OUTPUT_CURRENT_LOW_FLAG_EN];
            high_esr_comp <= policy_ctrl[`LCS_POL_COMP];
        end
    end

    //------------------------------------------------------------
    // read path
    //------------------------------------------------------------
    reg [7:0] next_rd_data;
    // live status, reserved bits zero; writes to status addresses fall through
    always @* begin
        next_rd_data = 8'h00;
        case (reg_addr)
            `LCS_ADDR_DIAG_STATUS: begin
                next_rd_data[`LCS_ST1_OLF] = overload_flag;
                next_rd_data[`LCS_ST1_OUTPUT_VOLTAGE_LOW_FLAG] = output_voltage_low_flag;
                next_rd_data[`LCS_ST1_PDO] = pulldown_overcurrent_flag;
                next_rd_data[`LCS_ST1_OTF] = overtemperature_flag;
                next_rd_data[`LCS_ST1_UV] = input_undervoltage_flag;
            end
            `LCS_ADDR_TONE_STATUS: begin
                next_rd_data[`LCS_ST2_TONE] = tone_present_flag;
                next_rd_data[`LCS_ST2_TONE_OUT_OF_SPEC_FLAG] = tone_out_of_spec_flag;
                next_rd_data[`LCS_ST2_ILOW] = output_current_low_flag;
            end
            `LCS_ADDR_VSEL_CTRL: next_rd_data = vsel_ctrl;
            `LCS_ADDR_POLICY_CTRL: next_rd_data = policy_ctrl & `LCS_POL_MASK;
            default: next_rd_data = 8'h00;
        endcase
    end

    // read answer one cycle after the strobe; status never written
    always @(posedge mclk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_stb;
            if (rd_stb) begin
                rd_data <= next_rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/lcs_host.sv
// register access master for the control and status bank
`timescale 1ns/1ns
`default_nettype none
module lcs_host (
    input wire logic mclk,
    output logic wr_stb,
    output logic rd_stb,
    output logic [2:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    // idle bus at time zero
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        reg_addr = 3'h0;
        wr_data = 8'h00;
    end
    // one byte write; released lines show the inverse of the last value
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_stb <= 1'b1;
        reg_addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_stb <= 1'b0;
        reg_addr <= ~a;
        wr_data <= ~d;
    endtask
    // one byte read; answer is taken one edge after the strobe edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd_stb <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        reg_addr <= ~a;
        @(posedge mclk);
        d = rd_valid === 1'b1 ? rd_data : 8'hXX;
    endtask
endmodule
`default_nettype wire

// >>> sim/lcs_regs_chk.sv
// port assertions for the control and status register bank
`timescale 1ns/1ns
`default_nettype none
module lcs_regs_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic overload_det,
    input wire logic temp_above_hi,
    input wire logic [3:0] output_voltage_select,
    input wire logic output_enable,
    input wire logic current_monitor_enable,
    input wire logic diag_level_21v,
    input wire logic high_esr_comp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (rd_stb |=> rd_valid)
        else $error("read without answer");
    chk_valid_pulse: assert property (!rd_stb |=> !rd_valid)
        else $error("answer without read");
    chk_monitor_write: assert property (wr_stb && reg_addr == 3'h5 |-> ##2
        current_monitor_enable == $past(wr_data[0], 2) && diag_level_21v == $past(wr_data[0], 2))
        else $error("monitor enable not taken");
    chk_comp_write: assert property (wr_stb && reg_addr == 3'h5 |-> ##2
        high_esr_comp == $past(wr_data[7], 2)) else $error("compensation not taken");
    chk_policy_read: assert property (rd_stb && reg_addr == 3'h5 |=>
        rd_data[0] == current_monitor_enable && rd_data[7] == high_esr_comp
        && (rd_data & 8'h36) == 8'h00) else $error("policy read wrong");
    chk_status_reserved: assert property (rd_stb && reg_addr < 3'h2 |=>
        (rd_data & ($past(reg_addr) == 3'h0 ? 8'h2A : 8'hEA)) == 8'h00)
        else $error("reserved status bit set");
    chk_unmapped_zero: assert property (rd_stb && reg_addr > 3'h5 |=>
        rd_data == 8'h00) else $error("unmapped read nonzero");
    chk_select_write: assert property (wr_stb && reg_addr == 3'h2 && !overload_det
        && !temp_above_hi |-> ##2 output_voltage_select == $past(wr_data[3:0], 2))
        else $error("voltage select not taken");
    chk_off_when_zero: assert property (output_voltage_select == 4'h0 |->
        !output_enable) else $error("output on with zero select");
    chk_comp_stable: assert property (!$past(wr_stb) |=> $stable(high_esr_comp))
        else $error("compensation changed without write");
endmodule
bind lcs_regs lcs_regs_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .overload_det(overload_det), .temp_above_hi(temp_above_hi),
    .output_voltage_select(output_voltage_select), .output_enable(output_enable),
    .current_monitor_enable(current_monitor_enable), .diag_level_21v(diag_level_21v),
    .high_esr_comp(high_esr_comp));
`default_nettype wire

// >>> sim/lcs_regs_tb_top.sv
// self-checking bench for the control and status register bank
`timescale 1ns/1ns
`default_nettype none
module lcs_regs_tb_top;
    logic mclk;
    logic sys_rst = 1'b1;
    logic [8:0] cond = 9'h000;
    wire logic wr_stb, rd_stb, rd_valid, output_enable, diag_level_21v, cme, hec;
    wire logic [2:0] reg_addr;
    wire logic [7:0] wr_data, rd_data;
    wire logic [3:0] vsel;
    int failures = 0;
    int samples_checked = 0;
    int idx[7] = '{0, 1, 2, 5, 6, 7, 8};
    logic [7:0] pat[7] = '{8'h01, 8'h04, 8'h10, 8'h80, 8'h01, 8'h04, 8'h10};
    lcs_host i_host (.mclk(mclk), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
    lcs_regs #(.DEGLITCH_CYC(4)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .overload_det(cond[0]), .vout_low_det(cond[1]),
        .pulldown_oc_det(cond[2]), .temp_above_hi(cond[3]), .temp_below_lo(cond[4]),
        .supply_undervoltage_threshold(cond[5]), .tone_detection_input(cond[6]),
        .tone_out_of_limits(cond[7]), .iout_below_thr(cond[8]),
        .output_voltage_select(vsel), .output_enable(output_enable),
        .diag_level_21v(diag_level_21v), .current_monitor_enable(cme),
        .high_esr_comp(hec));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk8(d, exp);
    endtask
    task automatic set_cond(input logic [8:0] v, input int n);
        @(posedge mclk) cond <= v;
        cyc(n);
    endtask
    // each non-thermal condition input shows in its own status bit, live; thermal trips set and clear bit 6
    task automatic t_status;
        for (int k = 0; k < 7; k++) begin
            set_cond(9'h001 << idx[k], 12);
            rd_chk({2'b00, idx[k] > 5}, pat[k]);
            set_cond(9'h000, 12);
            rd_chk({2'b00, idx[k] > 5}, 8'h00);
        end
        set_cond(9'h004, 3);
        rd_chk(3'h0, 8'h00);
        set_cond(9'h000, 12);
        set_cond(9'h008, 12);
        set_cond(9'h000, 12);
        rd_chk(3'h0, 8'h40);
        set_cond(9'h010, 12);
        rd_chk(3'h0, 8'h00);
    endtask
    // fault on bit b with a given recovery policy, then host rewrite
    task automatic t_prot(input int b, input logic [7:0] pol);
        i_host.wr(3'h5, pol);
        i_host.wr(3'h2, 8'h05);
        set_cond(9'h001 << b, 8);
        chk8({output_enable, vsel}, pol != 8'h00 ? 8'h00 : 8'h05);
        set_cond(b == 3 ? 9'h010 : 9'h000, 8);
        chk8({output_enable, vsel}, pol != 8'h00 ? 8'h00 : 8'h15);
        i_host.wr(3'h2, 8'h05);
        cyc(3);
        chk8({output_enable, vsel}, 8'h15);
        i_host.wr(3'h2, 8'h00);
    endtask
    // control writes, read-only status, unmapped place, mid-run reset
    task automatic t_regs;
        i_host.wr(3'h5, 8'hFF);
        cyc(2);
        chk8({diag_level_21v, cme, hec}, 8'h07);
        rd_chk(3'h5, 8'hC9);
        i_host.wr(3'h0, 8'hFF);
        i_host.wr(3'h1, 8'hFF);
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h7, 8'h00);
        i_host.wr(3'h2, 8'hFF);
        rd_chk(3'h2, 8'h0F);
        set_cond(9'h000, 0);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        rd_chk(3'h5, 8'h00);
        chk8({vsel, output_enable, cme, hec}, 8'h00);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h1, 8'h00);
        t_regs();
        t_status();
        t_prot(0, 8'h00);
        t_prot(0, 8'h08);
        t_prot(3, 8'h00);
        t_prot(3, 8'h40);
        end_of_test();
    end
    // watchdog
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
